/* float_unit_params.svh */
`ifndef FLOAT_UNIT_PARAMS_SVH
`define FLOAT_UNIT_PARAMS_SVH

// Word layout and special encodings.
`define FPU_SIGN_BIT      31
`define FPU_EXP_ALL_ONES  8'hFF
`define FPU_QNAN          32'hFFC00000
`define FPU_INF_BODY      31'h7F800000
`define FPU_ZERO_BODY     31'h00000000
`define FPU_QUIET_BIT     22

// Exponent arithmetic on an 11-bit signed working exponent.
`define FPU_BIAS          11'sh07F
`define FPU_EXP_MAX       11'sh0FF
`define FPU_EXP_ZERO      11'sh000
`define FPU_EXP_ONE       11'sh001

// Working mantissa: 50 bits, carry at 49, leading one at 48.
`define W_OVF             49
`define W_LEAD            48
`define W_LSB             25
`define W_GUARD           24
`define ALIGN_LIMIT       8'h32

// Divider iterations: 27 quotient bits (24 + guard + 2 spare).
`define DIV_STEPS         5'h1B
`define DIV_LAST          5'h1A

// Status register bit positions.
`define FLAG_UNDERFLOW    0
`define FLAG_OVERFLOW     1
`define FLAG_INVALID      2
`define FLAG_DIVZERO      3
`define FLAG_DENORM       4
`define FLAG_COUNT        5
`define FLAGS_NONE        5'h00

`endif

/* float_unit_pkg.sv */
package float_unit_pkg;

  typedef enum logic [3:0] {
    op_add,
    op_sub,
    op_mul,
    op_div,
    compare_less_than_op,
    compare_equal_op,
    compare_less_equal_op,
    compare_greater_than_op,
    compare_not_equal_op,
    compare_greater_equal_op,
    compare_unordered_op
  } float_op_type;

  typedef enum {
    st_idle,
    st_divide,
    st_normalize,
    st_round
  } fpu_state_type;

endpackage : float_unit_pkg

/* float_operand_classify.sv */
`timescale 1ns/100ps
`include "float_unit_params.svh"

module float_operand_classify (
  input  wire logic [31:0] i_word,
  output logic             o_sign,
  output logic [7:0]       o_exp,
  output logic [23:0]      o_mant,
  output logic             o_zero,
  output logic             o_inf,
  output logic             o_nan,
  output logic             o_snan,
  output logic             o_denorm
);

  logic exp_ones;
  logic exp_zero;
  logic frac_zero;

  always_comb begin
    exp_ones  = (i_word[30:23] == `FPU_EXP_ALL_ONES);
    exp_zero  = (i_word[30:23] == 8'h00);
    frac_zero = (i_word[22:0] == 23'h000000);
    o_sign    = i_word[`FPU_SIGN_BIT];
    o_exp     = i_word[30:23];
    o_mant    = {~exp_zero, i_word[22:0]};
    o_nan     = exp_ones & ~frac_zero;
    o_snan    = o_nan & ~i_word[`FPU_QUIET_BIT];
    o_inf     = exp_ones & frac_zero;
    o_zero    = exp_zero & frac_zero;
    o_denorm  = exp_zero & ~frac_zero;
  end

endmodule : float_operand_classify

/* single_precision_float_unit.sv */
`timescale 1ns/100ps
`include "float_unit_params.svh"

// Overview of operation
// - Words are sign, 8-bit exponent, 23-bit fraction.
// - Exponent 255, nonzero fraction means not-a-number.
// - Exponent 255, zero fraction means signed infinity.
// - Normal value is 2^(e-127) times 1.fraction.
// - Zero exponent and fraction means signed zero.
// - Denormal operand gives quiet NaN, denormal flag.
// - Denormal result flushes to signed zero, underflow.
// - Quiet NaN operand to arithmetic returns the fixed NaN.
// - Overflow always returns signed infinity.
// - Round to nearest, ties to even.
// - Add, subtract, multiply and divide.
// - Seven comparisons including unordered.
// - Operands and results use general registers.
// - Sticky flags stay set until software clears.
// - Enabled exceptions raise a hardware exception.
// - An exception suppresses the destination write.
module single_precision_float_unit (
  input  wire logic                         i_mclk,
  input  wire logic                         i_rstn,
  input  wire logic                         i_valid,
  input  wire float_unit_pkg::float_op_type i_op,
  input  wire logic [31:0]                  i_opa,
  input  wire logic [31:0]                  i_opb,
  input  wire logic                         i_exc_enable,
  input  wire logic [`FLAG_COUNT-1:0]       i_flag_clear,
  output logic                              o_busy,
  output logic                              o_done,
  output logic                              o_wr_en,
  output logic [31:0]                       o_result,
  output logic                              o_exception,
  output logic [`FLAG_COUNT-1:0]            o_float_status_register
);

  logic        a_sign, a_zero, a_inf, a_nan, a_snan, a_den;
  logic        b_sign, b_zero, b_inf, b_nan, b_snan, b_den;
  logic [7:0]  a_exp, b_exp;
  logic [23:0] a_mant, b_mant;

  float_operand_classify u_class_a (
    .i_word   (i_opa),
    .o_sign   (a_sign),
    .o_exp    (a_exp),
    .o_mant   (a_mant),
    .o_zero   (a_zero),
    .o_inf    (a_inf),
    .o_nan    (a_nan),
    .o_snan   (a_snan),
    .o_denorm (a_den)
  );

  float_operand_classify u_class_b (
    .i_word   (i_opb),
    .o_sign   (b_sign),
    .o_exp    (b_exp),
    .o_mant   (b_mant),
    .o_zero   (b_zero),
    .o_inf    (b_inf),
    .o_nan    (b_nan),
    .o_snan   (b_snan),
    .o_denorm (b_den)
  );

  float_unit_pkg::fpu_state_type state_q, state_d;
  logic [49:0]              w_q, w_d;
  logic signed [10:0]       e_q, e_d;
  logic                     s_q, s_d;
  logic [25:0]              rem_q, rem_d;
  logic [24:0]              dvs_q, dvs_d;
  logic [4:0]               cnt_q, cnt_d;
  logic                     busy_q, busy_d;
  logic                     done_q, done_d;
  logic                     wr_q, wr_d;
  logic                     exc_q, exc_d;
  logic [31:0]              res_q, res_d;
  logic [`FLAG_COUNT-1:0]   flags_q, flags_d;

  logic                     fin;
  logic [31:0]              r;
  logic [`FLAG_COUNT-1:0]   ev;
  logic                     trap;
  logic                     sb_eff;
  logic                     unord, eq, lt, cmp_bit;
  logic                     a_big;
  logic [7:0]               diff;
  logic [49:0]              big_w, small_w, aligned;
  logic                     lost;
  logic [47:0]              prod;
  logic                     qbit;
  logic [25:0]              rem_next;
  logic [26:0]              quo;
  logic                     rnd_up;
  logic [24:0]              mr;
  logic signed [10:0]       er;

  // Zeros of either sign compare equal; other values order by sign then magnitude.
  function automatic logic less_than(input logic [31:0] a, input logic [31:0] b,
                                     input logic az, input logic bz);
    if (az && bz) begin
      return 1'b0;
    end
    if (a[`FPU_SIGN_BIT] != b[`FPU_SIGN_BIT]) begin
      return a[`FPU_SIGN_BIT];
    end
    if (a[`FPU_SIGN_BIT]) begin
      return a[30:0] > b[30:0];
    end
    return a[30:0] < b[30:0];
  endfunction : less_than

  always_comb begin
    state_d  = state_q;
    w_d      = w_q;
    e_d      = e_q;
    s_d      = s_q;
    rem_d    = rem_q;
    dvs_d    = dvs_q;
    cnt_d    = cnt_q;
    busy_d   = busy_q;
    done_d   = 1'b0;
    wr_d     = 1'b0;
    exc_d    = 1'b0;
    res_d    = res_q;
    flags_d  = flags_q & ~i_flag_clear;
    fin      = 1'b0;
    r        = res_q;
    ev       = `FLAGS_NONE;
    trap     = 1'b0;
    sb_eff   = b_sign ^ (i_op == float_unit_pkg::op_sub);
    unord    = a_nan | b_nan;
    eq       = ~unord & ((a_zero & b_zero) | (i_opa == i_opb));
    lt       = ~unord & less_than(i_opa, i_opb, a_zero, b_zero);
    a_big    = {a_exp, a_mant} >= {b_exp, b_mant};
    diff     = a_big ? (a_exp - b_exp) : (b_exp - a_exp);
    big_w    = a_big ? {1'b0, a_mant, 25'h0000000} : {1'b0, b_mant, 25'h0000000};
    small_w  = a_big ? {1'b0, b_mant, 25'h0000000} : {1'b0, a_mant, 25'h0000000};
    if (diff >= `ALIGN_LIMIT) begin
      aligned = 50'h0;
      lost    = 1'b1;
    end else begin
      aligned = small_w >> diff;
      lost    = |(small_w & ~({50{1'b1}} << diff));
    end
    aligned  = aligned | {49'h0, lost};
    prod     = a_mant * b_mant;
    qbit     = rem_q >= {1'b0, dvs_q};
    rem_next = qbit ? ((rem_q - {1'b0, dvs_q}) << 1) : (rem_q << 1);
    quo      = {w_q[25:0], qbit};
    rnd_up   = w_q[`W_GUARD] & ((|w_q[`W_GUARD-1:0]) | w_q[`W_LSB]);
    mr       = {1'b0, w_q[`W_LEAD:`W_LSB]} + {24'h000000, rnd_up};
    er       = e_q + (mr[24] ? `FPU_EXP_ONE : `FPU_EXP_ZERO);
    case (i_op)
      float_unit_pkg::compare_less_than_op:     cmp_bit = lt;
      float_unit_pkg::compare_equal_op:         cmp_bit = eq;
      float_unit_pkg::compare_less_equal_op:    cmp_bit = lt | eq;
      float_unit_pkg::compare_greater_than_op:  cmp_bit = ~unord & ~lt & ~eq;
      float_unit_pkg::compare_not_equal_op:     cmp_bit = ~eq;
      float_unit_pkg::compare_greater_equal_op: cmp_bit = ~unord & ~lt;
      default:                                  cmp_bit = unord;
    endcase

    case (state_q)
      float_unit_pkg::st_idle: begin
        if (i_valid) begin
          busy_d = 1'b1;
          if (a_den | b_den) begin
            fin              = 1'b1;
            r                = `FPU_QNAN;
            ev[`FLAG_DENORM] = 1'b1;
          end else if (i_op >= float_unit_pkg::compare_less_than_op) begin
            fin               = 1'b1;
            r                 = {31'h00000000, cmp_bit};
            ev[`FLAG_INVALID] = a_snan | b_snan;
          end else if (a_nan | b_nan) begin
            fin               = 1'b1;
            r                 = `FPU_QNAN;
            ev[`FLAG_INVALID] = a_snan | b_snan;
          end else begin
            case (i_op)
              float_unit_pkg::op_add, float_unit_pkg::op_sub: begin
                if (a_inf & b_inf & (a_sign != sb_eff)) begin
                  fin               = 1'b1;
                  r                 = `FPU_QNAN;
                  ev[`FLAG_INVALID] = 1'b1;
                end else if (a_inf | b_inf) begin
                  fin = 1'b1;
                  r   = {a_inf ? a_sign : sb_eff, `FPU_INF_BODY};
                end else if (a_zero & b_zero) begin
                  fin = 1'b1;
                  r   = {a_sign & sb_eff, `FPU_ZERO_BODY};
                end else begin
                  s_d     = a_big ? a_sign : sb_eff;
                  e_d     = $signed({3'b000, a_big ? a_exp : b_exp});
                  w_d     = (a_sign == sb_eff) ? (big_w + aligned) : (big_w - aligned);
                  state_d = float_unit_pkg::st_normalize;
                end
              end
              float_unit_pkg::op_mul: begin
                s_d = a_sign ^ b_sign;
                if ((a_inf & b_zero) | (a_zero & b_inf)) begin
                  fin               = 1'b1;
                  r                 = `FPU_QNAN;
                  ev[`FLAG_INVALID] = 1'b1;
                end else if (a_inf | b_inf) begin
                  fin = 1'b1;
                  r   = {a_sign ^ b_sign, `FPU_INF_BODY};
                end else if (a_zero | b_zero) begin
                  fin = 1'b1;
                  r   = {a_sign ^ b_sign, `FPU_ZERO_BODY};
                end else begin
                  e_d     = $signed({3'b000, a_exp}) + $signed({3'b000, b_exp}) - `FPU_BIAS;
                  w_d     = {prod, 2'b00};
                  state_d = float_unit_pkg::st_normalize;
                end
              end
              default: begin
                s_d = a_sign ^ b_sign;
                if ((a_zero & b_zero) | (a_inf & b_inf)) begin
                  fin               = 1'b1;
                  r                 = `FPU_QNAN;
                  ev[`FLAG_INVALID] = 1'b1;
                end else if (a_inf | b_zero) begin
                  fin               = 1'b1;
                  r                 = {a_sign ^ b_sign, `FPU_INF_BODY};
                  ev[`FLAG_DIVZERO] = b_zero;
                end else if (a_zero | b_inf) begin
                  fin = 1'b1;
                  r   = {a_sign ^ b_sign, `FPU_ZERO_BODY};
                end else begin
                  e_d     = $signed({3'b000, a_exp}) - $signed({3'b000, b_exp}) + `FPU_BIAS;
                  rem_d   = {2'b00, a_mant};
                  dvs_d   = {1'b0, b_mant};
                  cnt_d   = 5'h00;
                  w_d     = 50'h0;
                  state_d = float_unit_pkg::st_divide;
                end
              end
            endcase
          end
        end
      end
      float_unit_pkg::st_divide: begin
        // One quotient bit per cycle keeps the divider small at the cost of latency.
        rem_d = rem_next;
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == `DIV_LAST) begin
          w_d     = {1'b0, quo, 21'h000000, rem_next != 26'h0};
          state_d = float_unit_pkg::st_normalize;
        end else begin
          w_d = {23'h000000, quo};
        end
      end
      float_unit_pkg::st_normalize: begin
        if (w_q == 50'h0) begin
          fin = 1'b1;
          r   = {1'b0, `FPU_ZERO_BODY};
        end else if (w_q[`W_OVF]) begin
          w_d = {1'b0, w_q[`W_OVF:2], w_q[1] | w_q[0]};
          e_d = e_q + `FPU_EXP_ONE;
        end else if (!w_q[`W_LEAD]) begin
          // Left shifts are exact: deep cancellation only follows a small alignment.
          w_d = w_q << 1;
          e_d = e_q - `FPU_EXP_ONE;
        end else begin
          state_d = float_unit_pkg::st_round;
        end
      end
      float_unit_pkg::st_round: begin
        fin = 1'b1;
        if (er >= `FPU_EXP_MAX) begin
          r                  = {s_q, `FPU_INF_BODY};
          ev[`FLAG_OVERFLOW] = 1'b1;
        end else if (er <= `FPU_EXP_ZERO) begin
          r                   = {s_q, `FPU_ZERO_BODY};
          ev[`FLAG_UNDERFLOW] = 1'b1;
        end else begin
          r = {s_q, er[7:0], mr[24] ? 23'h000000 : mr[22:0]};
        end
      end
      default: begin
        state_d = float_unit_pkg::st_idle;
        busy_d  = 1'b0;
      end
    endcase

    if (fin) begin
      trap    = i_exc_enable & (|ev);
      res_d   = r;
      done_d  = 1'b1;
      exc_d   = trap;
      wr_d    = ~trap;
      busy_d  = 1'b0;
      state_d = float_unit_pkg::st_idle;
      flags_d = flags_d | ev;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_q <= float_unit_pkg::st_idle;
      w_q     <= 50'h0;
      e_q     <= `FPU_EXP_ZERO;
      s_q     <= 1'b0;
      rem_q   <= 26'h0;
      dvs_q   <= 25'h0;
      cnt_q   <= 5'h00;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      wr_q    <= 1'b0;
      exc_q   <= 1'b0;
      res_q   <= 32'h00000000;
      flags_q <= `FLAGS_NONE;
    end else begin
      state_q <= state_d;
      w_q     <= w_d;
      e_q     <= e_d;
      s_q     <= s_d;
      rem_q   <= rem_d;
      dvs_q   <= dvs_d;
      cnt_q   <= cnt_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
      wr_q    <= wr_d;
      exc_q   <= exc_d;
      res_q   <= res_d;
      flags_q <= flags_d;
    end
  end

  assign o_busy                  = busy_q;
  assign o_done                  = done_q;
  assign o_wr_en                 = wr_q;
  assign o_result                = res_q;
  assign o_exception             = exc_q;
  assign o_float_status_register = flags_q;

endmodule : single_precision_float_unit

/* single_precision_float_unit_sva.sv */
`timescale 1ns/100ps
`include "float_unit_params.svh"

module float_unit_checker (
  input wire logic                         i_mclk,
  input wire logic                         i_rstn,
  input wire logic                         i_valid,
  input wire float_unit_pkg::float_op_type i_op,
  input wire logic [31:0]                  i_opa,
  input wire logic [31:0]                  i_opb,
  input wire logic                         i_exc_enable,
  input wire logic [`FLAG_COUNT-1:0]       i_flag_clear,
  input wire logic                         o_busy,
  input wire logic                         o_done,
  input wire logic                         o_wr_en,
  input wire logic [31:0]                  o_result,
  input wire logic                         o_exception,
  input wire logic [`FLAG_COUNT-1:0]       o_float_status_register
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  logic take;
  logic cmp_op;
  logic arith_op;
  logic den_a;
  logic den_b;
  logic qn_a;
  logic qn_b;
  logic nrm_a;
  logic nrm_b;

  assign take     = i_valid && !o_busy;
  assign cmp_op   = i_op >= float_unit_pkg::compare_less_than_op;
  assign arith_op = i_op <= float_unit_pkg::op_div;
  assign den_a    = (i_opa[30:23] == 8'h00) && (i_opa[22:0] != 23'h000000);
  assign den_b    = (i_opb[30:23] == 8'h00) && (i_opb[22:0] != 23'h000000);
  assign qn_a     = (i_opa[30:23] == `FPU_EXP_ALL_ONES) && i_opa[`FPU_QUIET_BIT];
  assign qn_b     = (i_opb[30:23] == `FPU_EXP_ALL_ONES) && i_opb[`FPU_QUIET_BIT];
  assign nrm_a    = (i_opa[30:23] != 8'h00) && (i_opa[30:23] != `FPU_EXP_ALL_ONES);
  assign nrm_b    = (i_opb[30:23] != 8'h00) && (i_opb[30:23] != `FPU_EXP_ALL_ONES);

  property p_done_write; o_done |-> (o_wr_en ^ o_exception); endproperty
  a_done_write: assert property (p_done_write) else $error("done without exactly one of write or trap");
  property p_write_done; (o_wr_en || o_exception) |-> o_done; endproperty
  a_write_done: assert property (p_write_done) else $error("write or trap outside done");
  property p_sticky;
    (($past(o_float_status_register) & ~$past(i_flag_clear)) & ~o_float_status_register) == `FLAGS_NONE;
  endproperty
  a_sticky: assert property (p_sticky) else $error("status flag dropped without clear");
  property p_cmp_bit; (take && cmp_op && !den_a && !den_b) |=> (o_done && o_result[31:1] == 31'h00000000); endproperty
  a_cmp_bit: assert property (p_cmp_bit) else $error("compare result not zero or one");
  property p_cmp_fast; (take && cmp_op) |=> o_done; endproperty
  a_cmp_fast: assert property (p_cmp_fast) else $error("compare not answered next cycle");
  property p_denorm;
    (take && (den_a || den_b)) |=> (o_done && o_result == `FPU_QNAN && o_float_status_register[`FLAG_DENORM]);
  endproperty
  a_denorm: assert property (p_denorm) else $error("denormal operand not flagged");
  property p_qnan; (take && arith_op && (qn_a || qn_b)) |=> (o_done && o_result == `FPU_QNAN); endproperty
  a_qnan: assert property (p_qnan) else $error("quiet nan operand passed through");
  // Done is registered on the 29th or 30th edge after the take, so it is sampled high one edge later.
  property p_div_time; (take && i_op == float_unit_pkg::op_div && nrm_a && nrm_b) |-> ##[30:31] o_done; endproperty
  a_div_time: assert property (p_div_time) else $error("divide latency out of range");
  property p_bound; take |-> ##[1:52] o_done; endproperty
  a_bound: assert property (p_bound) else $error("request never answered");
  property p_done_idle; o_done |-> !o_busy; endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy still set with done");
  property p_busy_mul;
    (take && i_op == float_unit_pkg::op_mul && nrm_a && nrm_b) |=> (o_busy && !o_done);
  endproperty
  a_busy_mul: assert property (p_busy_mul) else $error("multiply not held busy");

  c_div: cover property (take && i_op == float_unit_pkg::op_div);
  c_trap: cover property (o_exception);
  c_cmp_nan: cover property (take && cmp_op && (qn_a || qn_b));
endmodule : float_unit_checker

bind single_precision_float_unit float_unit_checker u_chk (
  .i_mclk, .i_rstn, .i_valid, .i_op, .i_opa, .i_opb, .i_exc_enable, .i_flag_clear,
  .o_busy, .o_done, .o_wr_en, .o_result, .o_exception, .o_float_status_register
);

/* gpr_file_model.sv */
`timescale 1ns/100ps

module gpr_file_model (
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic        i_wr_en,
  input  wire logic [3:0]  i_index,
  input  wire logic [31:0] i_wr_data,
  output logic [31:0]      o_rd_data
);
  logic [31:0] gpr_q [16];

  // Float results share the general registers, so a suppressed write must leave the old value.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      for (int k = 0; k < 16; k++) begin
        gpr_q[k] <= 32'h00000000;
      end
    end else if (i_wr_en) begin
      gpr_q[i_index] <= i_wr_data;
    end
  end
  assign o_rd_data = gpr_q[i_index];
endmodule : gpr_file_model

/* single_precision_float_unit_tb.sv */
`timescale 1ns/100ps
`include "float_unit_params.svh"

module single_precision_float_unit_tb;
  typedef struct {
    float_unit_pkg::float_op_type op;
    logic [31:0]                  a;
    logic [31:0]                  b;
    logic [31:0]                  r;
    logic [4:0]                   f;
  } row_type;

  logic                         i_mclk;
  logic                         i_rstn;
  logic                         i_valid;
  float_unit_pkg::float_op_type i_op;
  logic [31:0]                  i_opa;
  logic [31:0]                  i_opb;
  logic                         i_exc_enable;
  logic [`FLAG_COUNT-1:0]       i_flag_clear;
  logic                         o_busy;
  logic                         o_done;
  logic                         o_wr_en;
  logic [31:0]                  o_result;
  logic                         o_exception;
  logic [`FLAG_COUNT-1:0]       o_float_status_register;
  logic [3:0]                   reg_index;
  logic [31:0]                  reg_data;
  logic [31:0]                  res_seen;
  logic                         wr_seen;
  logic                         exc_seen;
  int                           miscompares;
  int                           samples_checked;
  int                           cycles;
  row_type                      rows [15];
  logic [31:0]                  cmp_a [4];
  logic [31:0]                  cmp_b [4];
  logic [6:0]                   cmp_exp [4];

  single_precision_float_unit DUT (
    .i_mclk, .i_rstn, .i_valid, .i_op, .i_opa, .i_opb, .i_exc_enable, .i_flag_clear,
    .o_busy, .o_done, .o_wr_en, .o_result, .o_exception, .o_float_status_register
  );

  gpr_file_model u_gpr (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_wr_en(o_wr_en), .i_index(reg_index), .i_wr_data(o_result),
    .o_rd_data(reg_data)
  );

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic run_op(input float_unit_pkg::float_op_type op, input logic [31:0] a, input logic [31:0] b);
    int   n;
    logic busy_seen;
    @(posedge i_mclk);
    #1;
    i_valid = 1'b1;
    i_op = op;
    i_opa = a;
    i_opb = b;
    @(posedge i_mclk);
    #1;
    i_valid = 1'b0;
    busy_seen = o_busy;
    n = 0;
    while (o_done !== 1'b1 && n < 60) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    check("done", 32'h00000001, {31'h0, o_done});
    check("busy", {31'h0, n > 0}, {31'h0, busy_seen});
    check("idle_at_done", 32'h00000000, {31'h0, o_busy});
    res_seen = o_result;
    wr_seen = o_wr_en;
    exc_seen = o_exception;
  endtask : run_op

  task automatic clear_flags(input logic [4:0] mask);
    @(posedge i_mclk);
    #1;
    i_flag_clear = mask;
    @(posedge i_mclk);
    #1;
    i_flag_clear = 5'h00;
  endtask : clear_flags

  initial begin
    rows = '{
      '{float_unit_pkg::op_add, 32'h3F800000, 32'h40000000, 32'h40400000, 5'h00},
      '{float_unit_pkg::op_sub, 32'h40400000, 32'h3F800000, 32'h40000000, 5'h00},
      '{float_unit_pkg::op_mul, 32'h3FC00000, 32'h40000000, 32'h40400000, 5'h00},
      '{float_unit_pkg::op_div, 32'h3F800000, 32'h40800000, 32'h3E800000, 5'h00},
      '{float_unit_pkg::op_add, 32'h3F800000, 32'h33800000, 32'h3F800000, 5'h00},
      '{float_unit_pkg::op_add, 32'h3F800001, 32'h33800000, 32'h3F800002, 5'h00},
      '{float_unit_pkg::op_add, 32'h7FC00000, 32'h3F800000, 32'hFFC00000, 5'h00},
      '{float_unit_pkg::op_add, 32'h7F800000, 32'h3F800000, 32'h7F800000, 5'h00},
      '{float_unit_pkg::op_add, 32'h00000000, 32'h80000000, 32'h00000000, 5'h00},
      '{float_unit_pkg::op_mul, 32'h00000001, 32'h3F800000, 32'hFFC00000, 5'h10},
      '{float_unit_pkg::op_mul, 32'h7F7FFFFF, 32'h40000000, 32'h7F800000, 5'h02},
      '{float_unit_pkg::op_mul, 32'h80800000, 32'h3F000000, 32'h80000000, 5'h01},
      '{float_unit_pkg::op_div, 32'h3F800000, 32'h00000000, 32'h7F800000, 5'h08},
      '{float_unit_pkg::op_sub, 32'h7F800000, 32'h7F800000, 32'hFFC00000, 5'h04},
      '{float_unit_pkg::op_add, 32'hFF800001, 32'h3F800000, 32'hFFC00000, 5'h04}
    };
    cmp_a = '{32'h3F800000, 32'h40000000, 32'h7FC00000, 32'h80000000};
    cmp_b = '{32'h40000000, 32'h40000000, 32'h3F800000, 32'h00000000};
    cmp_exp = '{7'h15, 7'h26, 7'h50, 7'h26};
    i_rstn = 1'b0;
    i_valid = 1'b0;
    i_op = float_unit_pkg::op_add;
    i_opa = 32'h00000000;
    i_opb = 32'h00000000;
    i_exc_enable = 1'b0;
    i_flag_clear = 5'h00;
    reg_index = 4'h0;
    repeat (6) @(posedge i_mclk);
    #1;
    i_rstn = 1'b1;
    check("reset_flags", 32'h00000000, {27'h0, o_float_status_register});
    for (int i = 0; i < 15; i++) begin
      clear_flags(5'h1F);
      reg_index = 4'(i);
      run_op(rows[i].op, rows[i].a, rows[i].b);
      check("result", rows[i].r, res_seen);
      check("write", 32'h00000001, {31'h0, wr_seen});
      check("flags", {27'h0, rows[i].f}, {27'h0, o_float_status_register});
      @(posedge i_mclk);
      #1;
      check("register", rows[i].r, reg_data);
    end
    $display("test arithmetic done");
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 7; k++) begin
        run_op(float_unit_pkg::float_op_type'(4 + k), cmp_a[p], cmp_b[p]);
        check("compare", {31'h0, cmp_exp[p][k]}, res_seen);
      end
    end
    $display("test compare done");
    clear_flags(5'h1F);
    reg_index = 4'h9;
    run_op(float_unit_pkg::op_add, 32'h3F800000, 32'h40000000);
    i_exc_enable = 1'b1;
    run_op(float_unit_pkg::op_mul, 32'h7F7FFFFF, 32'h40000000);
    check("trap", 32'h00000001, {31'h0, exc_seen});
    check("trap_write", 32'h00000000, {31'h0, wr_seen});
    check("trap_result", 32'h7F800000, res_seen);
    i_exc_enable = 1'b0;
    @(posedge i_mclk);
    #1;
    check("kept_register", 32'h40400000, reg_data);
    $display("test trap done");
    run_op(float_unit_pkg::op_add, 32'h3F800000, 32'h3F800000);
    check("sticky", 32'h00000002, {27'h0, o_float_status_register});
    clear_flags(5'h02);
    check("cleared", 32'h00000000, {27'h0, o_float_status_register});
    $display("test sticky done");
    complete_run();
  end
endmodule : single_precision_float_unit_tb
